// ### core/srx_aux_top.sv
// s/pdif receiver lock-lost flag and aux tdm output with avalon register slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
//
// Function
// - once lock has been held and is then lost, the sticky lock-lost flag goes to 1 and stays there.
// - the lock-lost flag returns to 0 only when a 1 is written to the audio-restart bit.
// - with aux output enabled, the selected port sends an eight-slot tdm stream of decoded data.
// - slot 0 holds the 24 left audio bits then eight zeros.
// - slot 1 holds 20 zeros, left parity, validity, user and status bits, then eight zeros.
// - slot 2 holds 22 zeros, compression type, audio type, then eight zeros.
// - slots 3 and 6 are all 32 zeros.
// - slot 4 holds the 24 right audio bits then eight zeros.
// - slot 5 holds 20 zeros, right parity, validity, user and status bits, then eight zeros.
// - slot 7 holds 23 zeros, the block-start bit, then eight zeros.
// - a four-bit select field picks the output port, 0001 choosing port 0.
// - select 0010, 0100 and 1000 choose ports 1 to 3 and 0000 turns the output off.
// - clock source 0 drives the port clocks from the clocks recovered from the input stream.
// - clock source 1 uses generator three, which software must set up with reference 1110 and source 1.
`include "srx_consts.svh"
module srx_aux_top
  import srx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // decoder side, same clock
  input wire logic rx_locked,
  input wire logic [23:0] audio_left,
  input wire logic [23:0] audio_right,
  input wire logic [3:0] aux_left,
  input wire logic [3:0] aux_right,
  input wire logic compr_type,
  input wire logic audio_type,
  input wire logic block_start,
  output logic restart_audio,
  output logic lock_lost_sticky,
  // link clocks, asynchronous
  input wire logic rec_bclk,
  input wire logic rec_lrclk,
  input wire logic gen_bclk,
  input wire logic gen_lrclk,
  // serial output ports
  output logic [3:0] serial_data_output_n,
  output logic [3:0] serial_bit_clock_output_n,
  output logic [3:0] serial_frame_clock_output_n,
  // interrupt
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************

  // one-hot select codes only; anything else keeps the output quiet
  function automatic srx_port_t port_decode(input logic [3:0] sel);
    srx_port_t p;
    case (sel)
      `SRX_SEL_P0: p = `SRX_SEL_P0;
      `SRX_SEL_P1: p = `SRX_SEL_P1;
      `SRX_SEL_P2: p = `SRX_SEL_P2;
      `SRX_SEL_P3: p = `SRX_SEL_P3;
      default: p = `SRX_SEL_OFF;
    endcase
    return p;
  endfunction : port_decode

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) r[7:0] = new_v[7:0];
    if (be[1]) r[15:8] = new_v[15:8];
    return r;
  endfunction : lane_merge

  // ****************************************
  // declarations
  // ****************************************
  srx_frame_if fif ();

  logic req;
  logic ack_q;
  logic wr_fire;
  logic [15:0] idx;
  logic [15:0] rd_mux;
  logic [31:0] readdata_q;
  logic [15:0] wr_restart;
  logic [15:0] wr_aux;
  logic restart_q;
  logic [3:0] sel_q;
  logic clksrc_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_evt;
  logic [1:0] irq_w1c;
  logic lock_lost_q;
  logic locked_q;
  logic lost_evt;
  logic restart_clr;
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic bclk_sel;
  logic lr_sel;
  logic bclk_q;
  logic lrclk_q;
  srx_port_t port_en;
  logic aux_run;
  srx_slot_t slot [`SRX_SLOTS];
  srx_frame_t frame_d;
  srx_frame_t frame_q;
  logic [3:0] sdo_q;
  logic [3:0] bco_q;
  logic [3:0] fco_q;

  // ****************************************
  // avalon slave
  // ****************************************

  // fixed one wait state keeps the read mux off the bus critical path
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign idx = avs_address[17:2];
  assign avs_readdata = readdata_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_mux = `SRX_RST16;
    case (idx)
      `SRX_IDX_RESTART: rd_mux[`SRX_RESTART_BIT] = restart_q;
      `SRX_IDX_LOCK: rd_mux[`SRX_LOCK_BIT] = lock_lost_q;
      `SRX_IDX_AUX_EN: rd_mux[`SRX_CLKSRC_BIT:0] = {clksrc_q, sel_q};
      `SRX_IDX_IRQ_STAT: rd_mux[1:0] = irq_stat_q;
      `SRX_IDX_IRQ_MASK: rd_mux[1:0] = irq_mask_q;
      default: rd_mux = `SRX_RST16;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      readdata_q <= {16'h0000, rd_mux};
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  assign wr_restart = lane_merge({15'h0000, restart_q}, avs_writedata[15:0], avs_byteenable[1:0]);
  assign wr_aux = lane_merge({11'h000, clksrc_q, sel_q}, avs_writedata[15:0], avs_byteenable[1:0]);

  // restart bit is an ordinary level; writing 0 back is allowed at any time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      restart_q <= 1'b0;
    end else if (wr_fire && idx == `SRX_IDX_RESTART) begin
      restart_q <= wr_restart[`SRX_RESTART_BIT];
    end
  end

  assign restart_audio = restart_q;

  // aux output select and clock source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_q <= `SRX_RST_SEL;
      clksrc_q <= 1'b0;
    end else if (wr_fire && idx == `SRX_IDX_AUX_EN) begin
      sel_q <= wr_aux[`SRX_SEL_MSB:0];
      clksrc_q <= wr_aux[`SRX_CLKSRC_BIT];
    end
  end

  // ****************************************
  // lock-lost flag
  // ****************************************
  assign lost_evt = locked_q & ~rx_locked;
  assign restart_clr = wr_fire & (idx == `SRX_IDX_RESTART) & avs_byteenable[0] & avs_writedata[`SRX_RESTART_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= rx_locked;
    end
  end

  // a loss in the clearing cycle wins, so no loss is ever hidden
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_lost_q <= 1'b0;
    end else if (lost_evt) begin
      lock_lost_q <= 1'b1;
    end else if (restart_clr) begin
      lock_lost_q <= 1'b0;
    end
  end

  assign lock_lost_sticky = lock_lost_q;

  // ****************************************
  // interrupts
  // ****************************************
  assign irq_evt = {fif.frame_rise & aux_run, lost_evt};
  assign irq_w1c = (wr_fire && idx == `SRX_IDX_IRQ_STAT && avs_byteenable[0]) ? avs_writedata[1:0] : 2'b00;

  // set beats write-one-clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
    end else begin
      irq_stat_q <= irq_evt | (irq_stat_q & ~irq_w1c);
      if (wr_fire && idx == `SRX_IDX_IRQ_MASK && avs_byteenable[0]) begin
        irq_mask_q <= avs_writedata[1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // link clock sampling
  // ****************************************

  // two flops per pin; only sync_q is looked at
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {gen_lrclk, gen_bclk, rec_lrclk, rec_bclk};
      sync_q <= meta_q;
    end
  end

  // switching source mid-frame may show a stray edge; the frame edge resyncs
  assign bclk_sel = clksrc_q ? sync_q[2] : sync_q[0];
  assign lr_sel = clksrc_q ? sync_q[3] : sync_q[1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_q <= 1'b0;
      lrclk_q <= 1'b0;
    end else begin
      bclk_q <= bclk_sel;
      lrclk_q <= lr_sel;
    end
  end

  assign port_en = port_decode(sel_q);
  assign aux_run = |port_en;

  assign fif.run = aux_run;
  assign fif.bit_fall = bclk_q & ~bclk_sel;
  assign fif.frame_rise = ~lrclk_q & lr_sel;

  // ****************************************
  // frame assembly
  // ****************************************
  always_comb begin
    slot[0] = {audio_left, 8'h00};
    slot[1] = {20'h0_0000, aux_left, 8'h00};
    slot[2] = {22'h00_0000, compr_type, audio_type, 8'h00};
    slot[3] = 32'h0000_0000;
    slot[4] = {audio_right, 8'h00};
    slot[5] = {20'h0_0000, aux_right, 8'h00};
    slot[6] = 32'h0000_0000;
    slot[7] = {23'h00_0000, block_start, 8'h00};
  end

  // slot 0 at the top so the serializer walks slots in ascending order
  genvar gi;
  generate
    for (gi = 0; gi < `SRX_SLOTS; gi++) begin : g_pack
      assign frame_d[`SRX_FRAME_BITS - 1 - gi * `SRX_SLOT_BITS -: `SRX_SLOT_BITS] = slot[gi];
    end
  endgenerate

  // snapshot at the frame edge so a frame never mixes two samples
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_q <= '0;
    end else if (fif.frame_rise) begin
      frame_q <= frame_d;
    end
  end

  assign fif.frame_word = frame_q;

  srx_tdm_ser u_ser (
    .clk(clk),
    .nrst(nrst),
    .f(fif.ser)
  );

  // ****************************************
  // port routing
  // ****************************************

  // this end drives the port clocks, so the port must be set as master
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdo_q <= 4'h0;
      bco_q <= 4'h0;
      fco_q <= 4'h0;
    end else begin
      sdo_q <= port_en & {4{fif.sdata}};
      bco_q <= port_en & {4{bclk_q}};
      fco_q <= port_en & {4{lrclk_q}};
    end
  end

  assign serial_data_output_n = sdo_q;
  assign serial_bit_clock_output_n = bco_q;
  assign serial_frame_clock_output_n = fco_q;

endmodule : srx_aux_top

// ### core/srx_consts.svh
// register indices, field positions, reset values and frame layout constants
`ifndef SRX_CONSTS_SVH
`define SRX_CONSTS_SVH

// ****************************************
// register word indices (byte address is four times the index)
// ****************************************
`define SRX_IDX_RESTART 16'hF604
`define SRX_IDX_LOCK 16'hF605
`define SRX_IDX_AUX_EN 16'hF608
`define SRX_IDX_IRQ_STAT 16'hF6F0
`define SRX_IDX_IRQ_MASK 16'hF6F1
`define SRX_ADDR_W 18

// ****************************************
// field positions and reset values
// ****************************************
`define SRX_RESTART_BIT 0
`define SRX_LOCK_BIT 0
`define SRX_SEL_MSB 3
`define SRX_CLKSRC_BIT 4
`define SRX_IRQ_LOCK 0
`define SRX_IRQ_FRAME 1
`define SRX_RST16 16'h0000
`define SRX_RST_SEL 4'h0

// ****************************************
// output select codes
// ****************************************
`define SRX_SEL_OFF 4'b0000
`define SRX_SEL_P0 4'b0001
`define SRX_SEL_P1 4'b0010
`define SRX_SEL_P2 4'b0100
`define SRX_SEL_P3 4'b1000

// ****************************************
// frame layout
// ****************************************
`define SRX_SLOTS 8
`define SRX_SLOT_BITS 32
`define SRX_FRAME_BITS 256
`define SRX_LAST_BIT 8'hFF

`endif

// ### core/srx_frame_if.sv
// carrier between frame assembly and serializer
`timescale 1ns/1ps
interface srx_frame_if;
  import srx_pkg::*;
  srx_frame_t frame_word;
  logic run;
  logic bit_fall;
  logic frame_rise;
  logic sdata;

  modport src (output frame_word, output run, output bit_fall, output frame_rise, input sdata);
  modport ser (input frame_word, input run, input bit_fall, input frame_rise, output sdata);
endinterface : srx_frame_if

// ### core/srx_pkg.sv
// types shared by the aux tdm block
package srx_pkg;

  // serializer states, one-hot
  typedef enum logic [2:0] {
    srx_st_idle = 3'b001,
    srx_st_armed = 3'b010,
    srx_st_shift = 3'b100
  } srx_ser_state_e;

  typedef logic [31:0] srx_slot_t;
  typedef logic [3:0] srx_port_t;
  typedef logic [255:0] srx_frame_t;

endpackage : srx_pkg

// ### core/srx_tdm_ser.sv
// msb-first serializer for the eight-slot aux frame
`timescale 1ns/1ps
`include "srx_consts.svh"
module srx_tdm_ser
  import srx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // frame carrier
  srx_frame_if.ser f
);

  srx_ser_state_e state_q;
  logic [7:0] cnt_q;
  logic sdata_q;

  assign f.sdata = sdata_q;

  // ****************************************
  // frame sequencing
  // ****************************************

  // a frame edge always restarts, so a lost bit clock heals at the next frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= srx_st_idle;
      cnt_q <= 8'h00;
    end else if (!f.run) begin
      state_q <= srx_st_idle;
      cnt_q <= 8'h00;
    end else if (f.frame_rise) begin
      state_q <= srx_st_armed;
      cnt_q <= 8'h00;
    end else begin
      case (state_q)
        srx_st_idle: begin
          state_q <= srx_st_idle;
        end
        srx_st_armed: begin
          if (f.bit_fall) begin
            state_q <= srx_st_shift;
            cnt_q <= 8'h01;
          end
        end
        srx_st_shift: begin
          if (f.bit_fall) begin
            if (cnt_q == `SRX_LAST_BIT) begin
              state_q <= srx_st_idle; // wait for the next frame edge
            end
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: begin
          state_q <= srx_st_idle;
        end
      endcase
    end
  end

  // ****************************************
  // data bit
  // ****************************************

  // frame_word bit 255 leaves on the first bit clock fall after the frame edge, bit 0 on the 256th
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sdata_q <= 1'b0;
    end else if (!f.run || state_q == srx_st_idle) begin
      sdata_q <= 1'b0;
    end else if (f.bit_fall && !f.frame_rise) begin
      sdata_q <= f.frame_word[`SRX_LAST_BIT - cnt_q];
    end
  end

endmodule : srx_tdm_ser

// ### tb/srx_aux_properties.sv
// concurrent checks on the aux tdm top ports
`timescale 1ns/1ps
`include "srx_consts.svh"
module srx_aux_chk (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register bus
  input wire logic [17:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // decoder and link side
  input wire logic rx_locked,
  input wire logic restart_audio,
  input wire logic lock_lost_sticky,
  input wire logic rec_bclk,
  input wire logic gen_bclk,
  // serial ports
  input wire logic [3:0] serial_data_output_n,
  input wire logic [3:0] serial_bit_clock_output_n
);
  logic wr_ok;
  logic clr;
  logic cfg_wr;
  logic [4:0] cfg_q;
  logic [3:0] age_q;
  logic [3:0] act;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // strobes at the edge where a write takes effect
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign clr = wr_ok && avs_address[17:2] == `SRX_IDX_RESTART && avs_writedata[0];
  assign cfg_wr = wr_ok && avs_address[17:2] == `SRX_IDX_AUX_EN;
  assign act = serial_data_output_n | serial_bit_clock_output_n;
  // mirror of select and clock source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q <= 5'h00;
    end else if (cfg_wr) begin
      cfg_q <= avs_writedata[4:0];
    end
  end
  // age since a config write; the port pipe lags a few cycles, so checks wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      age_q <= 4'h0;
    end else if (cfg_wr) begin
      age_q <= 4'h0;
    end else if (age_q != 4'hf) begin
      age_q <= age_q + 4'h1;
    end
  end
  // ****
  // properties
  // ****
  AST_LOCK_SET: assert property ($fell(rx_locked) |-> ##[1:2] lock_lost_sticky)
    else $error("lock loss not flagged");
  AST_LOCK_CAUSE: assert property ($rose(lock_lost_sticky) |-> !$past(rx_locked) || !$past(rx_locked, 2))
    else $error("flag set without lock loss");
  AST_LOCK_HOLD: assert property (lock_lost_sticky && !clr |=> lock_lost_sticky)
    else $error("flag dropped without restart");
  AST_LOCK_CLEAR: assert property (clr && rx_locked && $past(rx_locked) |=> !lock_lost_sticky)
    else $error("restart did not clear flag");
  AST_RESTART: assert property (wr_ok && avs_address[17:2] == `SRX_IDX_RESTART |=>
    restart_audio == $past(avs_writedata[0])) else $error("restart bit not written");
  AST_ROUTE: assert property (age_q == 4'hf |-> (act & ~cfg_q[3:0]) == 4'h0)
    else $error("activity on unselected port");
  AST_OFF: assert property (age_q == 4'hf && !$onehot(cfg_q[3:0]) |-> act == 4'h0)
    else $error("activity with output off");
  AST_BIT_EDGE: assert property (age_q == 4'hf && $changed(serial_data_output_n) |->
    $fell(|serial_bit_clock_output_n)) else $error("data moved off bit clock fall");
  AST_REC_CLK: assert property (age_q == 4'hf && !cfg_q[4] && $rose(|serial_bit_clock_output_n) |->
    $past(rec_bclk, 2) || $past(rec_bclk, 3) || $past(rec_bclk, 4) || $past(rec_bclk, 5))
    else $error("bit clock not from recovered clock");
  AST_GEN_CLK: assert property (age_q == 4'hf && cfg_q[4] && $rose(|serial_bit_clock_output_n) |->
    $past(gen_bclk, 2) || $past(gen_bclk, 3) || $past(gen_bclk, 4) || $past(gen_bclk, 5))
    else $error("bit clock not from generator");
endmodule : srx_aux_chk

bind srx_aux_top srx_aux_chk u_chk (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .rx_locked(rx_locked), .restart_audio(restart_audio), .lock_lost_sticky(lock_lost_sticky),
  .rec_bclk(rec_bclk), .gen_bclk(gen_bclk), .serial_data_output_n(serial_data_output_n),
  .serial_bit_clock_output_n(serial_bit_clock_output_n));

// ### tb/srx_tdm_rx.sv
// downstream tdm receiver model listening on one serial output port
`timescale 1ns/1ps
module srx_tdm_rx (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // port pins
  input wire logic [1:0] port,
  input wire logic [3:0] sdata,
  input wire logic [3:0] bclk,
  input wire logic [3:0] lrclk,
  // last whole frame
  output logic [255:0] frame_q,
  output int frames_q
);
  logic b_q;
  logic l_q;
  logic on_q;
  logic [255:0] sh_q;
  int cnt_q;
  // clock slave: bit taken on bit clock rise, frame opened by frame clock rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b_q <= 1'b0;
      l_q <= 1'b0;
      on_q <= 1'b0;
      sh_q <= 256'h0;
      frame_q <= 256'h0;
      cnt_q <= 0;
      frames_q <= 0;
    end else begin
      b_q <= bclk[port];
      if (bclk[port] && !b_q) begin
        l_q <= lrclk[port];
        if (on_q && cnt_q < 256) begin
          sh_q <= {sh_q[254:0], sdata[port]};
          cnt_q <= cnt_q + 1;
        end
        if (on_q && cnt_q == 255) begin
          frame_q <= {sh_q[254:0], sdata[port]};
          frames_q <= frames_q + 1;
        end
        if (lrclk[port] && !l_q) begin
          on_q <= 1'b1;
          cnt_q <= 0;
        end
      end
    end
  end
endmodule : srx_tdm_rx

// ### tb/test_srx_aux_top.sv
// bench for the aux tdm block: registers, lock flag, irq and frames
`timescale 1ns/1ps
`include "srx_consts.svh"
module test_srx_aux_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [17:0] avs_address = 18'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic rx_locked = 1'b1;
  logic [23:0] audio_left = 24'h0;
  logic [23:0] audio_right = 24'h0;
  logic [3:0] aux_left = 4'h0;
  logic [3:0] aux_right = 4'h0;
  logic compr_type = 1'b0;
  logic audio_type = 1'b0;
  logic block_start = 1'b0;
  logic rec_bclk = 1'b0;
  logic rec_lrclk = 1'b0;
  logic gen_bclk = 1'b0;
  logic gen_lrclk = 1'b0;
  logic use_gen = 1'b0;
  logic [1:0] port = 2'h0;
  logic [8:0] lk = 9'h0;
  logic [31:0] rdata;
  logic [31:0] q_bus;
  logic wreq;
  logic restart;
  logic lost;
  logic irq;
  logic [3:0] sdo;
  logic [3:0] sbo;
  logic [3:0] sfo;
  logic [255:0] rx_frame;
  int frames;
  int err_total = 0;
  int n_tests = 0;
  srx_aux_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .rx_locked(rx_locked), .audio_left(audio_left), .audio_right(audio_right), .aux_left(aux_left),
    .aux_right(aux_right), .compr_type(compr_type), .audio_type(audio_type), .block_start(block_start),
    .restart_audio(restart), .lock_lost_sticky(lost), .rec_bclk(rec_bclk), .rec_lrclk(rec_lrclk),
    .gen_bclk(gen_bclk), .gen_lrclk(gen_lrclk), .serial_data_output_n(sdo), .serial_bit_clock_output_n(sbo),
    .serial_frame_clock_output_n(sfo), .irq(irq));
  srx_tdm_rx peer (.clk(clk), .nrst(nrst), .port(port), .sdata(sdo), .bclk(sbo), .lrclk(sfo),
    .frame_q(rx_frame), .frames_q(frames));
  // system clock
  initial begin
    forever #4 clk = ~clk;
  end
  // link clocks: only the chosen source runs, the other stands still
  initial begin
    #3;
    forever begin
      #40;
      lk = lk + 9'h1;
      rec_bclk = !use_gen && !lk[0];
      rec_lrclk = !use_gen && lk[8];
      gen_bclk = use_gen && !lk[0];
      gen_lrclk = use_gen && lk[8];
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_frame(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_frame
  // one avalon cycle; holds the request until waitrequest is seen low
  task automatic bus_go(input logic rd, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_byteenable <= 4'h3;
    avs_read <= rd;
    avs_write <= !rd;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) err_total++;
  endtask : bus_go
  task automatic bus_wr(input logic [15:0] idx, input logic [31:0] d);
    bus_go(1'b0, idx, d, q_bus);
  endtask : bus_wr
  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    bus_go(1'b1, idx, 32'h0, q_bus);
    chk_reg(q_bus, exp);
  endtask : rd_chk
  task automatic chk_pins(input logic [31:0] exp);
    @(posedge clk);
    chk_reg({29'h0, irq, restart, lost}, exp);
  endtask : chk_pins
  task automatic wait_frame();
    int f;
    int n;
    f = frames;
    n = 0;
    while (frames == f && n < 6000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 6000) err_total++;
  endtask : wait_frame
  function automatic logic [255:0] exp_frame();
    return {audio_left, 8'h0, 20'h0, aux_left, 8'h0, 22'h0, compr_type, audio_type, 8'h0, 32'h0,
      audio_right, 8'h0, 20'h0, aux_right, 8'h0, 32'h0, 23'h0, block_start, 8'h0};
  endfunction : exp_frame
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  // watchdog against a hang
  initial begin
    #600000;
    err_total++;
    test_done();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] s;
    void'($urandom(32'hdf23));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    bus_wr(16'hf605, 32'h1);
    bus_wr(16'hf606, 32'hffff);
    for (int i = 0; i < 6; i++) begin
      rd_chk(i < 5 ? 16'hf604 + i[15:0] : `SRX_IDX_IRQ_STAT, 32'h0);
    end
    rd_chk(`SRX_IDX_IRQ_MASK, 32'h0);
    bus_wr(`SRX_IDX_IRQ_MASK, 32'h1);
    rx_locked <= 1'b0;
    repeat (4) @(posedge clk);
    rx_locked <= 1'b1;
    rd_chk(16'hf605, 32'h1);
    bus_wr(16'hf604, 32'h0);
    chk_pins(32'h5);
    bus_wr(16'hf604, 32'h1);
    rd_chk(16'hf605, 32'h0);
    bus_wr(16'hf604, 32'h0);
    rd_chk(16'hf604, 32'h0);
    chk_pins(32'h4);
    bus_wr(`SRX_IDX_IRQ_MASK, 32'h0);
    chk_pins(32'h0);
    bus_wr(`SRX_IDX_IRQ_MASK, 32'h1);
    bus_wr(`SRX_IDX_IRQ_STAT, 32'h1);
    chk_pins(32'h0);
    // every port, both clock sources; first frame carries all ones
    for (int i = 0; i < 4; i++) begin
      use_gen = i[0];
      port <= i[1:0];
      bus_wr(16'hf608, {27'h0, i[0], 4'h1 << i});
      rd_chk(16'hf608, {27'h0, i[0], 4'h1 << i});
      wait (lk[8:7] == 2'b00);
      @(posedge clk);
      r = (i == 0) ? 32'hffff_ffff : $urandom;
      s = (i == 0) ? 32'hffff_ffff : $urandom;
      audio_left <= r[23:0];
      audio_right <= s[23:0];
      aux_left <= r[27:24];
      aux_right <= s[27:24];
      compr_type <= r[28];
      audio_type <= r[29];
      block_start <= s[28];
      wait_frame();
      wait_frame();
      chk_frame(rx_frame, exp_frame());
    end
    rd_chk(`SRX_IDX_IRQ_STAT, 32'h2);
    bus_wr(`SRX_IDX_IRQ_MASK, 32'h2);
    chk_pins(32'h4);
    // a code that is not one-hot must keep every port quiet, as 0000 does
    for (int k = 0; k < 2; k++) begin
      bus_wr(16'hf608, k == 0 ? 32'h3 : 32'h0);
      rd_chk(16'hf608, k == 0 ? 32'h3 : 32'h0);
      repeat (300) @(posedge clk);
      chk_reg({20'h0, sdo, sbo, sfo}, 32'h0);
    end
    test_done();
  end
endmodule : test_srx_aux_top
